// ### src/mec_pkg.sv
// Constants, types and frame layout for the motor and encoder config parser.
// Assumes one clock domain and a byte stream already framed by the link.
// Overview of operation
// - Motor-settings body stored whole in settings memory
// - Identity code, 70-byte request, 4-byte code echo
// - Identity kept nonvolatile, maker-unlock only
// - Encoder-settings code, 54-byte request, code echo
// - Flag 0x1 differential, 0x4 push-pull
// - Flag 0x10 index, 0x40 revolution sensor
// - Flag 0x100 selects revolution sensor polarity
// - Encoder settings kept nonvolatile, maker-unlock only
// - Kind code, 14-byte request, code echo
// - Motor kinds 0 none, 1,2,3,5 decoded
// - Motor kind 4 fixed-duty test, maker only
// - Driver kinds 1 bridge default, 2, 3
// - Motor and driver kind updated together
package mec_pkg;
    localparam logic [31:0] CODE_MOTOR   = 32'h676E6573;
    localparam logic [31:0] CODE_IDENT   = 32'h696E6573;
    localparam logic [31:0] CODE_ENC     = 32'h736E6573;
    localparam logic [31:0] CODE_KIND    = 32'h746E6573;
    localparam int          CODE_BYTES   = 4;
    localparam int          CRC_BYTES    = 2;
    localparam int          LEN_MOTOR    = 34;
    localparam int          LEN_IDENT    = 70;
    localparam int          LEN_ENC      = 54;
    localparam int          LEN_KIND     = 14;
    localparam logic [7:0]  BODY_MOTOR   =
        8'(LEN_MOTOR - CODE_BYTES - CRC_BYTES);
    localparam logic [7:0]  BODY_IDENT   =
        8'(LEN_IDENT - CODE_BYTES - CRC_BYTES);
    localparam logic [7:0]  BODY_ENC     =
        8'(LEN_ENC - CODE_BYTES - CRC_BYTES);
    localparam logic [7:0]  BODY_KIND    =
        8'(LEN_KIND - CODE_BYTES - CRC_BYTES);
    localparam int          BODY_MAX     = 64;
    localparam int          MOTOR_BYTES  = 28;
    localparam int          IDENT_BYTES  = 40;
    localparam int          ENC_PERREV   = 16;
    localparam int          ENC_FLAGS    = 20;
    localparam int          FLAG_DIFF    = 0;
    localparam int          FLAG_PUSHPULL = 2;
    localparam int          FLAG_INDEX   = 4;
    localparam int          FLAG_REVPRES = 6;
    localparam int          FLAG_REVHIGH = 8;
    localparam logic [7:0]  MOTOR_NONE   = 8'h00;
    localparam logic [7:0]  MOTOR_TEST   = 8'h04;
    localparam logic [7:0]  MOTOR_MAX    = 8'h05;
    localparam logic [7:0]  DRIVER_BRIDGE = 8'h01;
    localparam logic [7:0]  DRIVER_MAX   = 8'h03;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_FLAGS    = 8'h08;
    localparam logic [7:0]  REG_PERREV   = 8'h0C;
    localparam logic [7:0]  REG_KINDS    = 8'h10;
    localparam logic [7:0]  REG_ANALOG   = 8'h20;
    localparam logic [7:0]  REG_MOTOR    = 8'h40;
    localparam logic [7:0]  REG_IDENT    = 8'h80;
    localparam logic [3:0]  MOTOR_WORDS  = 4'h7;
    localparam logic [3:0]  IDENT_WORDS  = 4'hA;
    localparam logic [1:0]  ECHO_LAST    = 2'h3;
    localparam logic [7:0]  CODE_LAST    = 8'h03;

    typedef enum logic [1:0] {ST_CODE, ST_BODY, ST_CRC, ST_ECHO} mec_state_t;
endpackage

// ### src/mec_config_cmds.sv
// Byte-stream parser for motor, encoder identity, encoder and kind writes.
// Assumes rx bytes and tx ready are synchronous to ref_clk.
`timescale 1ns/100ps
module mec_config_cmds (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    output logic             rxReady,
    output logic             txValid,
    output logic [7:0]       txData,
    input  wire logic        txReady,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdData,
    input  wire logic        revSensorIn,
    output logic             revSensorActive,
    output logic             diffOutput,
    output logic             pushPullOutput,
    output logic             indexPresent,
    output logic             revSensorPresent,
    output logic [7:0]       motorKind,
    output logic [7:0]       driverKind,
    output logic             testMode
);
    typedef struct packed {
        mec_pkg::mec_state_t          st;
        logic [31:0]                  code;
        logic [7:0]                   cnt;
        logic [7:0]                   need;
        logic [15:0]                  sum;
        logic [7:0]                   crcLow;
        logic [mec_pkg::BODY_MAX-1:0][7:0]    body;
        logic [1:0]                   echoIdx;
        logic [mec_pkg::MOTOR_BYTES-1:0][7:0] motorSet;
        logic [mec_pkg::IDENT_BYTES-1:0][7:0] ident;
        logic [3:0][31:0]             analog;
        logic [31:0]                  perRev;
        logic [31:0]                  flags;
        logic [7:0]                   motorKind;
        logic [7:0]                   driverKind;
        logic                         testMode;
        logic                         unlock;
        logic [7:0]                   okCnt;
        logic [7:0]                   badCnt;
        logic                         revActive;
        logic                         rxReady;
        logic                         txValid;
        logic [7:0]                   txData;
        logic [31:0]                  rdData;
    } mec_regs_t;

    mec_regs_t q;
    mec_regs_t d;
    logic      crcLast;
    logic      crcGood;
    logic      allowed;
    logic [3:0] motorWord;
    logic [3:0] identWord;

    assign crcLast   = q.st == mec_pkg::ST_CRC && q.cnt == 8'h01
                       && rxValid && q.rxReady;
    assign crcGood   = {rxData, q.crcLow} == q.sum;
    assign motorWord = {1'b0, regAddr[4:2]};
    assign identWord = regAddr[5:2];

    always_comb begin
        case (q.code)
            mec_pkg::CODE_IDENT: allowed = q.unlock;
            mec_pkg::CODE_ENC:   allowed = q.unlock;
            mec_pkg::CODE_KIND: begin
                allowed = q.body[0] != mec_pkg::MOTOR_NONE
                          && q.body[0] <= mec_pkg::MOTOR_MAX
                          && (q.body[0] != mec_pkg::MOTOR_TEST
                              || q.unlock)
                          && q.body[1] >= mec_pkg::DRIVER_BRIDGE
                          && q.body[1] <= mec_pkg::DRIVER_MAX;
            end
            default: allowed = 1'b1;
        endcase
    end

    always_comb begin
        d = q;
        if (rxValid && q.rxReady) begin
            case (q.st)
                mec_pkg::ST_CODE: begin
                    d.code = {rxData, q.code[31:8]};
                    if (q.cnt == mec_pkg::CODE_LAST) begin
                        d.cnt = 8'h00;
                        d.sum = 16'h0000;
                        d.st  = mec_pkg::ST_BODY;
                        case (d.code)
                            mec_pkg::CODE_MOTOR:
                                d.need = mec_pkg::BODY_MOTOR;
                            mec_pkg::CODE_IDENT:
                                d.need = mec_pkg::BODY_IDENT;
                            mec_pkg::CODE_ENC:
                                d.need = mec_pkg::BODY_ENC;
                            mec_pkg::CODE_KIND:
                                d.need = mec_pkg::BODY_KIND;
                            default: begin
                                d.st  = mec_pkg::ST_CODE;
                                d.cnt = mec_pkg::CODE_LAST;
                            end
                        endcase
                    end else begin
                        d.cnt = q.cnt + 8'h01;
                    end
                end
                mec_pkg::ST_BODY: begin
                    d.body[q.cnt[5:0]] = rxData;
                    d.sum = q.sum + {8'h00, rxData};
                    d.cnt = q.cnt + 8'h01;
                    if (q.cnt == q.need - 8'h01) begin
                        d.cnt = 8'h00;
                        d.st  = mec_pkg::ST_CRC;
                    end
                end
                mec_pkg::ST_CRC: begin
                    if (q.cnt == 8'h00) begin
                        d.crcLow = rxData;
                        d.cnt    = 8'h01;
                    end else if (crcGood && allowed) begin
                        d.okCnt   = q.okCnt + 8'h01;
                        d.st      = mec_pkg::ST_ECHO;
                        d.echoIdx = 2'h0;
                        d.txValid = 1'b1;
                        d.txData  = q.code[7:0];
                        case (q.code)
                            mec_pkg::CODE_MOTOR: begin
                                d.motorSet =
                                    q.body[mec_pkg::MOTOR_BYTES-1:0];
                            end
                            mec_pkg::CODE_IDENT: begin
                                d.ident =
                                    q.body[mec_pkg::IDENT_BYTES-1:0];
                            end
                            mec_pkg::CODE_ENC: begin
                                d.analog =
                                    q.body[mec_pkg::ENC_PERREV-1:0];
                                d.perRev =
                                    q.body[mec_pkg::ENC_PERREV +: 4];
                                d.flags  =
                                    q.body[mec_pkg::ENC_FLAGS +: 4];
                            end
                            mec_pkg::CODE_KIND: begin
                                d.motorKind  = q.body[0];
                                d.driverKind = q.body[1];
                                d.testMode   =
                                    q.body[0] == mec_pkg::MOTOR_TEST;
                            end
                            default: d.st = mec_pkg::ST_CODE;
                        endcase
                    end else begin
                        d.badCnt = q.badCnt + 8'h01;
                        d.st     = mec_pkg::ST_CODE;
                        d.cnt    = 8'h00;
                    end
                end
                default: d.st = q.st;
            endcase
        end
        if (q.st == mec_pkg::ST_ECHO && q.txValid && txReady) begin
            if (q.echoIdx == mec_pkg::ECHO_LAST) begin
                d.txValid = 1'b0;
                d.st      = mec_pkg::ST_CODE;
                d.cnt     = 8'h00;
            end else begin
                d.echoIdx = q.echoIdx + 2'h1;
                d.txData  = q.code[{d.echoIdx, 3'b000} +: 8];
            end
        end
        d.rxReady = d.st != mec_pkg::ST_ECHO;
        d.revActive = q.flags[mec_pkg::FLAG_REVPRES]
                      && (revSensorIn == q.flags[mec_pkg::FLAG_REVHIGH]);
        if (regWr && regAddr == mec_pkg::REG_CTRL) begin
            d.unlock = regWrData[0];
        end
        d.rdData = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                mec_pkg::REG_CTRL:   d.rdData = {31'h0, q.unlock};
                mec_pkg::REG_STATUS: begin
                    d.rdData = {14'h0, q.st, q.badCnt, q.okCnt};
                end
                mec_pkg::REG_FLAGS:  d.rdData = q.flags;
                mec_pkg::REG_PERREV: d.rdData = q.perRev;
                mec_pkg::REG_KINDS: begin
                    d.rdData = {16'h0, q.driverKind, q.motorKind};
                end
                mec_pkg::REG_ANALOG,
                mec_pkg::REG_ANALOG + 8'h04,
                mec_pkg::REG_ANALOG + 8'h08,
                mec_pkg::REG_ANALOG + 8'h0C: d.rdData = q.analog[regAddr[3:2]];
                default: begin
                    if (regAddr[7:5] == mec_pkg::REG_MOTOR[7:5]
                        && motorWord < mec_pkg::MOTOR_WORDS) begin
                        d.rdData = q.motorSet[{motorWord[2:0], 2'b00} +: 4];
                    end else if (regAddr[7:6] == mec_pkg::REG_IDENT[7:6]
                                 && identWord < mec_pkg::IDENT_WORDS) begin
                        d.rdData = q.ident[{identWord, 2'b00} +: 4];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q            <= '0;
            q.st         <= mec_pkg::ST_CODE;
            q.rxReady    <= 1'b1;
            q.driverKind <= mec_pkg::DRIVER_BRIDGE;
        end else begin
            q <= d;
        end
    end

    assign rxReady          = q.rxReady;
    assign txValid          = q.txValid;
    assign txData           = q.txData;
    assign regRdData        = q.rdData;
    assign revSensorActive  = q.revActive;
    assign diffOutput       = q.flags[mec_pkg::FLAG_DIFF];
    assign pushPullOutput   = q.flags[mec_pkg::FLAG_PUSHPULL];
    assign indexPresent     = q.flags[mec_pkg::FLAG_INDEX];
    assign revSensorPresent = q.flags[mec_pkg::FLAG_REVPRES];
    assign motorKind        = q.motorKind;
    assign driverKind       = q.driverKind;
    assign testMode         = q.testMode;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_enterBody(logic [31:0] c);
        $rose(q.st == mec_pkg::ST_BODY) && q.code == c;
    endsequence

    a_ident_body_len: assert property (s_enterBody(mec_pkg::CODE_IDENT)
        |-> q.need == 8'd64) else $error("identity body length wrong");
    a_enc_body_len: assert property (s_enterBody(mec_pkg::CODE_ENC)
        |-> q.need == 8'd48) else $error("encoder body length wrong");
    a_kind_body_len: assert property (s_enterBody(mec_pkg::CODE_KIND)
        |-> q.need == 8'd8) else $error("kind body length wrong");
    a_motor_body_len: assert property (s_enterBody(mec_pkg::CODE_MOTOR)
        |-> q.need == 8'd28) else $error("motor body length wrong");
    a_echo_first_byte: assert property ($rose(q.st == mec_pkg::ST_ECHO)
        |-> txValid && txData == q.code[7:0] && !rxReady)
        else $error("echo did not start with code byte");
    a_echo_ends: assert property (txValid && txReady
        && q.echoIdx == 2'h3 |=> !txValid && rxReady)
        else $error("echo did not end after four bytes");
    a_bad_crc_keep: assert property (crcLast && !crcGood
        |=> $stable(q.flags) && $stable(q.motorKind) && $stable(q.motorSet)
        && q.badCnt == $past(q.badCnt) + 8'h01 && !txValid)
        else $error("bad checksum changed settings");
    a_kind_together: assert property (crcLast && crcGood && allowed
        && q.code == mec_pkg::CODE_KIND |=> motorKind == $past(q.body[0])
        && driverKind == $past(q.body[1]))
        else $error("kinds not updated together");
    a_test_locked: assert property ($changed(motorKind)
        && motorKind == mec_pkg::MOTOR_TEST |-> $past(q.unlock) && testMode)
        else $error("test mode entered while locked");
    a_rev_polarity: assert property (##1 revSensorActive ==
        $past(revSensorPresent
              && revSensorIn == q.flags[mec_pkg::FLAG_REVHIGH]))
        else $error("revolution sensor polarity wrong");

    sequence s_echoTake(logic [1:0] i);
        txValid && txReady && q.echoIdx == i;
    endsequence

    a_echo_second: assert property (s_echoTake(2'h0)
        |=> txValid && txData == q.code[15:8])
        else $error("second echo byte wrong");
    a_echo_third: assert property (s_echoTake(2'h1)
        |=> txValid && txData == q.code[23:16])
        else $error("third echo byte wrong");
    a_echo_fourth: assert property (s_echoTake(2'h2)
        |=> txValid && txData == q.code[31:24])
        else $error("fourth echo byte wrong");
    a_echo_holds_rx: assert property (q.st == mec_pkg::ST_ECHO
        |-> !rxReady && txValid)
        else $error("bytes taken during echo");
    a_ident_locked: assert property (crcLast && crcGood
        && q.code == mec_pkg::CODE_IDENT && !q.unlock |=> $stable(q.ident))
        else $error("identity stored while locked");
    a_enc_locked: assert property (crcLast && crcGood
        && q.code == mec_pkg::CODE_ENC && !q.unlock |=> $stable(q.flags)
        && $stable(q.perRev) && $stable(q.analog))
        else $error("encoder settings stored while locked");
    a_motor_store: assert property (crcLast && crcGood
        && q.code == mec_pkg::CODE_MOTOR
        |=> q.motorSet == $past(q.body[mec_pkg::MOTOR_BYTES-1:0]))
        else $error("motor settings not stored whole");
    a_flag_store: assert property (crcLast && crcGood && allowed
        && q.code == mec_pkg::CODE_ENC
        |=> q.flags == $past(q.body[mec_pkg::ENC_FLAGS +: 4]))
        else $error("encoder flag word not stored");
    a_motor_legal: assert property ($changed(motorKind)
        |-> motorKind != mec_pkg::MOTOR_NONE
        && motorKind <= mec_pkg::MOTOR_MAX)
        else $error("illegal motor kind stored");
    a_driver_legal: assert property (driverKind
        >= mec_pkg::DRIVER_BRIDGE && driverKind <= mec_pkg::DRIVER_MAX)
        else $error("illegal driver kind stored");
    a_rev_absent: assert property (!revSensorPresent
        |=> !revSensorActive) else $error("absent sensor shown active");
endmodule

// ### verification/mec_host_model.sv
// Host side: sends framed write requests and collects the code echo.
// Assumes the parser samples bytes and echo handshakes on ref_clk rising.
`timescale 1ns/100ps
module mec_host_model (
    input  wire logic       ref_clk,
    output logic            rxValid,
    output logic [7:0]      rxData,
    input  wire logic       rxReady,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output logic            txReady
);
    logic [31:0] echoWord;
    int          echoBytes;

    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        txReady = 1'b0;
        echoWord = 32'h0;
        echoBytes = 0;
    end

    // Byte held until an edge sees rxReady high
    task automatic put_byte(input logic [7:0] b);
        rxValid <= 1'b1;
        rxData <= b;
        do @(posedge ref_clk); while (rxReady !== 1'b1);
    endtask

    task automatic send_frame(input logic [31:0] code,
                              input logic [7:0]  body[$],
                              input logic        bad,
                              input logic        slow);
        logic [15:0] sum;
        sum = 16'h0;
        foreach (body[i]) sum += 16'(body[i]);
        if (bad) sum ^= 16'h0001;
        for (int i = 0; i < 4; i++) put_byte(code[8*i +: 8]);
        foreach (body[i]) put_byte(body[i]);
        put_byte(sum[7:0]);
        put_byte(sum[15:8]);
        rxValid <= 1'b0;
        rxData <= ~sum[15:8];
        echoBytes = 0;
        repeat (60) begin
            @(posedge ref_clk);
            if (txValid === 1'b1 && txReady === 1'b1 && echoBytes < 4) begin
                echoWord[8*echoBytes +: 8] = txData;
                echoBytes++;
            end
            txReady <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
        end
        txReady <= 1'b0;
    endtask
endmodule

// ### verification/mec_config_cmds_tb.sv
// Self-checking bench for the config command parser.
// Assumes the host model drives the byte stream; bench drives registers.
`timescale 1ns/100ps
module mec_config_cmds_tb;
    logic        ref_clk, rst_n, rxValid, rxReady, txValid, txReady;
    logic [7:0]  rxData, txData, regAddr, motorKind, driverKind, m, d, em, ed;
    logic [31:0] regWrData, regRdData, rd, f;
    logic        regWr, regRd, revSensorIn, revSensorActive, diffOutput;
    logic        pushPullOutput, indexPresent, revSensorPresent, testMode;
    int          num_errors, check_count, cycles, okN, badN;
    logic [7:0]  body[$];

    mec_config_cmds u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .txValid(txValid), .txData(txData), .txReady(txReady),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .revSensorIn(revSensorIn),
        .revSensorActive(revSensorActive), .diffOutput(diffOutput),
        .pushPullOutput(pushPullOutput), .indexPresent(indexPresent),
        .revSensorPresent(revSensorPresent), .motorKind(motorKind),
        .driverKind(driverKind), .testMode(testMode));
    mec_host_model u_host (.ref_clk(ref_clk), .rxValid(rxValid),
        .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
        .txData(txData), .txReady(txReady));

    always #12.5 ref_clk = ~ref_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        v = regRdData;
    endtask

    // Word k of the sent body, low byte first
    function automatic logic [31:0] word_of(input int k);
        return {body[4*k+3], body[4*k+2], body[4*k+1], body[4*k]};
    endfunction

    function automatic logic kind_ok(input logic [7:0] mk, dk,
                                     input logic unl);
        return (mk inside {8'h01, 8'h02, 8'h03, 8'h05} ||
                (mk == 8'h04 && unl)) && dk >= 8'h01 && dk <= 8'h03;
    endfunction

    task automatic frame(input logic [31:0] code, input logic ok,
                         input logic bad);
        u_host.send_frame(code, body, bad, 1'($urandom_range(0, 1)));
        check(32'(u_host.echoBytes), ok ? 32'h4 : 32'h0);
        if (ok) check(u_host.echoWord, code);
        if (ok) okN++;
        else badN++;
    endtask

    task automatic chk_words(input logic [7:0] a, input int n, input int k0);
        for (int k = 0; k < n; k++) begin
            reg_read(a + 8'(4*k), rd);
            check(rd, word_of(k0 + k));
        end
    endtask

    task automatic rand_body(input int n);
        body = {};
        repeat (n) body.push_back(8'($urandom));
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {regWr, regRd, revSensorIn} = 3'h0;
        regAddr = 8'h00;
        regWrData = 32'h0;
        void'($urandom(32'hFA30));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        check({motorKind, driverKind, 7'h0, testMode}, 24'h000100);
        em = 8'h00;
        ed = 8'h01;
        for (int u = 0; u < 2; u++) begin
            reg_write(mec_pkg::REG_CTRL, 32'(u));
            for (int mk = 0; mk < 7; mk++) begin
                m = 8'(mk);
                d = (u == 1 && mk != 4) ? 8'($urandom_range(0, 4))
                                        : 8'(mk % 3 + 1);
                body = {m, d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
                frame(mec_pkg::CODE_KIND, kind_ok(m, d, u[0]), 1'b0);
                if (kind_ok(m, d, u[0])) {em, ed} = {m, d};
                check(motorKind, em);
                check(driverKind, ed);
                check(testMode, em == 8'h04);
            end
        end
        body = {8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(mec_pkg::CODE_KIND, 1'b0, 1'b1);
        check({motorKind, driverKind}, {em, ed});
        reg_read(mec_pkg::REG_KINDS, rd);
        check(rd, {16'h0, ed, em});
        $display("kind tests done");
        reg_write(mec_pkg::REG_CTRL, 32'h0);
        rand_body(64);
        frame(mec_pkg::CODE_IDENT, 1'b0, 1'b0);
        reg_read(mec_pkg::REG_IDENT, rd);
        check(rd, 32'h0);
        rand_body(48);
        frame(mec_pkg::CODE_ENC, 1'b0, 1'b0);
        reg_read(mec_pkg::REG_FLAGS, rd);
        check(rd, 32'h0);
        reg_write(mec_pkg::REG_CTRL, 32'h1);
        rand_body(64);
        frame(mec_pkg::CODE_IDENT, 1'b1, 1'b0);
        chk_words(mec_pkg::REG_IDENT, 10, 0);
        $display("identity tests done");
        repeat (4) begin
            rand_body(48);
            frame(mec_pkg::CODE_ENC, 1'b1, 1'b0);
            f = word_of(5);
            check({diffOutput, pushPullOutput}, {f[0], f[2]});
            check({indexPresent, revSensorPresent}, {f[4], f[6]});
            for (int l = 0; l < 2; l++) begin
                revSensorIn <= l[0];
                repeat (3) @(posedge ref_clk);
                check(revSensorActive, f[6] && (l[0] == f[8]));
            end
            chk_words(mec_pkg::REG_ANALOG, 4, 0);
            chk_words(mec_pkg::REG_PERREV, 1, 4);
            chk_words(mec_pkg::REG_FLAGS, 1, 5);
        end
        $display("encoder tests done");
        reg_write(mec_pkg::REG_CTRL, 32'h0);
        rand_body(28);
        frame(mec_pkg::CODE_MOTOR, 1'b1, 1'b0);
        chk_words(mec_pkg::REG_MOTOR, 7, 0);
        reg_read(8'hFC, rd);
        check(rd, 32'h0);
        reg_read(mec_pkg::REG_STATUS, rd);
        check(rd, {14'h0, 2'(mec_pkg::ST_CODE), 8'(badN), 8'(okN)});
        $display("motor tests done");
        give_verdict();
    end
endmodule
